// ---- hdl/qpc_pkg.sv ----
// Purpose: Shared constants and types for the quadrature position counter
// Assumes: One clock domain, 16-bit position count
// Notes:   Mode field codes follow the encoder control layout
`default_nettype none
package qpc_pkg;

    // ****************************************************************
    // Widths and field layout
    // ****************************************************************
    localparam int COUNT_W     = 16;     // Position counter width
    localparam int MODE_W      = 3;      // Mode select width
    localparam int CTRL_W      = 16;     // Control register image width
    localparam int MODE_LSB    = 8;      // Mode field low bit
    localparam int DIR_BIT     = 11;     // Direction status bit

    localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;  // Counter reset value
    localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;  // Step size

    // ****************************************************************
    // Mode codes (bit 2 enables counting, bit 1 picks x4, bit 0 picks max reset)
    // ****************************************************************
    localparam logic [MODE_W-1:0] MODE_X2_INDEX = 3'h4;   // x2, index reset
    localparam logic [MODE_W-1:0] MODE_X2_MAX   = 3'h5;   // x2, max reset
    localparam logic [MODE_W-1:0] MODE_X4_INDEX = 3'h6;   // x4, index reset
    localparam logic [MODE_W-1:0] MODE_X4_MAX   = 3'h7;   // x4, max reset
    localparam int MODE_EN_BIT  = 2;     // Counting enabled
    localparam int MODE_X4_BIT  = 1;     // x4 edge rate
    localparam int MODE_MAX_BIT = 0;     // Reset on max match

    // Synchronised encoder lines
    typedef struct packed {
        logic ph_a;
        logic ph_b;
        logic idx;
    } qpc_lines_type;

    // Decode result state of the index qualifier
    typedef enum logic [1:0] {
        QPC_IDX_IDLE  = 2'b00,
        QPC_IDX_SEEN  = 2'b01
    } qpc_idx_state_type;

endpackage
`default_nettype wire

// ---- hdl/qpc_counter.sv ----
// Purpose: Quadrature decode and 16-bit up/down position counter
// Assumes: Encoder lines are asynchronous pins; single 100 MHz clock
// Notes:   Noise filters, error checking, timer mode and interrupts are absent
//
// Overview of operation
// - Phase A leading phase B counts forward
// - 16-bit counter steps by one per count pulse
// - Count direction chooses up or down
// - Three-bit mode field at control bits 10:8
// - Modes 100/101 count phase A edges only
// - Modes 110/111 count every edge of both
// - Reset on index (100/110) or max (101/111)
// - Direction shown as read-only control bit 11
`timescale 1ns/10ps
`default_nettype none
module qpc_counter
(
    input  wire logic                             clk,
    input  wire logic                             sys_rst,
    input  wire logic                             clk_en,
    input  wire logic                             phase_a_input,
    input  wire logic                             phase_b_input,
    input  wire logic                             index_input,
    input  wire logic [qpc_pkg::MODE_W-1:0]       encoder_mode_select,
    input  wire logic [qpc_pkg::COUNT_W-1:0]      max_count_limit,
    output logic      [qpc_pkg::COUNT_W-1:0]      position_count,
    output logic                                  count_direction,
    output logic      [qpc_pkg::CTRL_W-1:0]       encoder_control_reg,
    output logic                                  count_pulse
);
    import qpc_pkg::*;

    // ****************************************************************
    // Synchronisers and edge history
    // ****************************************************************
    qpc_lines_type sync_1;      // First stage, read only by sync_2
    qpc_lines_type sync_2;      // Second stage, safe to decode
    qpc_lines_type last;        // Previous decoded sample
    logic [MODE_W-1:0] mode;    // Registered mode select

    // Two-flop synchroniser on every encoder line
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync_1 <= '0;
            sync_2 <= '0;
        end
        else if (clk_en)
        begin
            sync_1 <= '{phase_a_input, phase_b_input, index_input};
            sync_2 <= sync_1;
        end
    end

    // History for edge detection, taken from the synchronised copy
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            last <= '0;
        else if (clk_en)
            last <= sync_2;
    end

    // Mode comes from same-clock logic; register it for a flop-fed view
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            mode <= '0;
        else if (clk_en)
            mode <= encoder_mode_select;
    end

    // ****************************************************************
    // Quadrature decode
    // ****************************************************************
    logic edge_a;       // Phase A toggled
    logic edge_b;       // Phase B toggled
    logic next_dir;     // Direction implied by this edge
    logic step;         // Count pulse this cycle
    logic idx_rise;     // Qualified index arrival
    logic at_max;       // Counter sits at the limit

    // Forward when A leads B: after an A edge, A differs from B;
    // after a B edge, A equals B. Simultaneous edges are invalid and dropped.
    always_comb
    begin
        edge_a   = sync_2.ph_a ^ last.ph_a;
        edge_b   = sync_2.ph_b ^ last.ph_b;
        next_dir = count_direction;
        if (edge_a && !edge_b)
            next_dir = sync_2.ph_a ^ sync_2.ph_b;
        else if (edge_b && !edge_a)
            next_dir = ~(sync_2.ph_a ^ sync_2.ph_b);
        // x2 counts A edges, x4 counts both; neither when mode is off
        if (!mode[MODE_EN_BIT] || (edge_a && edge_b))
            step = 1'b0;
        else if (mode[MODE_X4_BIT])
            step = edge_a | edge_b;
        else
            step = edge_a;
        // Index qualified by both phases low, as the encoder promises
        idx_rise = sync_2.idx && !last.idx && !sync_2.ph_a && !sync_2.ph_b;
        at_max   = (position_count == max_count_limit);
    end

    // Direction follows every decoded single-phase edge in any mode
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            count_direction <= 1'b0;
        else if (clk_en)
            count_direction <= next_dir;
    end

    // ****************************************************************
    // Position counter
    // ****************************************************************
    // Max reset wraps to zero going up, and below zero loads the limit,
    // so the count stays inside 0..limit in both directions.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            position_count <= COUNT_RST;
        else if (clk_en)
        begin
            if (mode[MODE_EN_BIT] && !mode[MODE_MAX_BIT] && idx_rise)
                position_count <= COUNT_RST;
            else if (step)
            begin
                if (next_dir)
                begin
                    if (mode[MODE_MAX_BIT] && at_max)
                        position_count <= COUNT_RST;
                    else
                        position_count <= position_count + COUNT_ONE;
                end
                else
                begin
                    if (mode[MODE_MAX_BIT] && position_count == COUNT_RST)
                        position_count <= max_count_limit;
                    else
                        position_count <= position_count - COUNT_ONE;
                end
            end
        end
    end

    // Count pulse exported for the rest of the unit
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            count_pulse <= 1'b0;
        else if (clk_en)
            count_pulse <= step;
    end

    // ****************************************************************
    // Control register image
    // ****************************************************************
    // Only the mode field and direction status are live; others read zero
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            encoder_control_reg <= '0;
        else if (clk_en)
        begin
            encoder_control_reg                          <= '0;
            encoder_control_reg[MODE_LSB +: MODE_W]      <= encoder_mode_select;
            encoder_control_reg[DIR_BIT]                 <= next_dir;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_fwd_a;
        clk_en && mode[MODE_EN_BIT] && edge_a && !edge_b
            && (sync_2.ph_a != sync_2.ph_b);
    endsequence

    AST_COUNT_UP: assert property (@(posedge clk) disable iff (sys_rst)
        s_fwd_a and (!(mode[MODE_MAX_BIT] && at_max)
            && !(!mode[MODE_MAX_BIT] && idx_rise))
        |=> position_count == $past(position_count) + COUNT_ONE)
        else $error("count did not step up");

    AST_DIR_FWD: assert property (@(posedge clk) disable iff (sys_rst)
        s_fwd_a |=> count_direction)
        else $error("A leading B not forward");

    AST_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && !step && !idx_rise |=> $stable(position_count))
        else $error("count moved without pulse");

    AST_X2_NO_B: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && !mode[MODE_X4_BIT] && edge_b && !edge_a |-> !step)
        else $error("x2 counted a B edge");

    AST_X4_B: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && mode[MODE_EN_BIT] && mode[MODE_X4_BIT] && edge_b && !edge_a |-> step)
        else $error("x4 missed a B edge");

    AST_IDX_RST: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && mode[MODE_EN_BIT] && !mode[MODE_MAX_BIT] && idx_rise
        |=> position_count == COUNT_RST)
        else $error("index did not reset count");

    AST_DIR_BIT: assert property (@(posedge clk) disable iff (sys_rst)
        encoder_control_reg[DIR_BIT] == count_direction)
        else $error("status bit differs from direction");

    AST_MODE_FIELD: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en |=> encoder_control_reg[MODE_LSB +: MODE_W] == mode)
        else $error("mode field image stale");

    AST_SYNC_LAT: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en [*2] |=> sync_2.ph_a == $past(phase_a_input, 2))
        else $error("synchroniser latency wrong");

endmodule
`default_nettype wire

// ---- tb/qpc_encoder_model.sv ----
// Purpose: Behavioural incremental encoder with two phases and index
// Assumes: Steps are commanded by the bench through tasks
// Notes:   Lines change just after a rising edge, spaced well apart
`timescale 1ns/10ps
`default_nettype none
module qpc_encoder_model
(
    input  wire logic clk,
    output var logic  phase_a,
    output var logic  phase_b,
    output var logic  index_pulse
);
    // ****************************************************************
    // Gray position, 0:00 1:10 2:11 3:01 as (A,B); up means A leads
    // ****************************************************************
    logic [1:0] gray_pos;   // Quarter-cycle position

    initial
    begin
        phase_a     = 1'b0;
        phase_b     = 1'b0;
        index_pulse = 1'b0;
        gray_pos    = 2'h0;
    end

    // One quarter step, then a gap so every edge is seen and settled
    task automatic step(input logic fwd);
        @(posedge clk);
        gray_pos = fwd ? gray_pos + 2'h1 : gray_pos - 2'h1;
        phase_a <= gray_pos[1] ^ gray_pos[0];
        phase_b <= gray_pos[1];
        repeat (6) @(posedge clk);
    endtask

    // Index only where both phases sit low, else nothing is sent
    task automatic pulse_index();
        if (gray_pos == 2'h0)
        begin
            @(posedge clk);
            index_pulse <= 1'b1;
            repeat (3) @(posedge clk);
            index_pulse <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// ---- tb/quadrature_position_counter_tb.sv ----
// Purpose: Self-checking bench for the quadrature position counter
// Assumes: Encoder model drives the pins; mode and limit set here
// Notes:   Expected counts worked out by hand per scenario
`timescale 1ns/10ps
`default_nettype none
module quadrature_position_counter_tb;
    import qpc_pkg::*;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic               clk;         // 100 MHz clock
    logic               sys_rst;     // Async reset
    logic               clk_en;      // Run enable, high except while s_freeze holds it low
    wire logic          ph_a;        // Phase A from the model
    wire logic          ph_b;        // Phase B from the model
    wire logic          idx;         // Index from the model
    logic [MODE_W-1:0]  mode;        // Mode field
    logic [COUNT_W-1:0] limit;       // Max count limit
    logic [COUNT_W-1:0] pos;         // Position seen
    logic               dir;         // Direction seen
    logic [CTRL_W-1:0]  ctrl;        // Control image seen
    logic               pulse;       // Count pulse seen
    int                 bad_count;
    int                 comparisons;
    int                 pulses;      // Count pulses observed

    qpc_encoder_model enc_inst (.clk(clk), .phase_a(ph_a), .phase_b(ph_b), .index_pulse(idx));
    qpc_counter qpc_counter_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .phase_a_input(ph_a), .phase_b_input(ph_b), .index_input(idx),
        .encoder_mode_select(mode), .max_count_limit(limit), .position_count(pos),
        .count_direction(dir), .encoder_control_reg(ctrl), .count_pulse(pulse));

    // Clock, and a tally of one-cycle pulses
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        if (pulse === 1'b1)
            pulses++;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic chk_all(input logic [15:0] p, input logic d);
        chk("position", pos, p);
        chk("direction", {15'h0, dir}, {15'h0, d});
        chk("control", ctrl, {4'h0, d, mode, 8'h00});
    endtask

    task automatic mv(input logic fwd, input int n);
        repeat (n) enc_inst.step(fwd);
    endtask

    task automatic set_mode(input logic [2:0] m, input logic [15:0] lim);
        @(posedge clk);
        mode  <= m;
        limit <= lim;
        repeat (3) @(posedge clk);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // x4 counting both ways, wrap below zero, index reset
    task automatic s_x4_index();
        set_mode(MODE_X4_INDEX, 16'h0003);
        mv(1'b1, 4);
        chk_all(16'h0004, 1'b1);
        mv(1'b0, 2);
        chk_all(16'h0002, 1'b0);
        mv(1'b0, 3);
        chk_all(16'hffff, 1'b0);
        mv(1'b1, 5);
        chk_all(16'h0004, 1'b1);
        enc_inst.pulse_index();
        chk_all(16'h0000, 1'b1);
    endtask

    // x2 with max reset: index ignored, wrap at limit both ways
    task automatic s_x2_max();
        set_mode(MODE_X2_MAX, 16'h0003);
        mv(1'b1, 4);
        chk_all(16'h0002, 1'b1);
        enc_inst.pulse_index();
        chk_all(16'h0002, 1'b1);
        mv(1'b1, 4);
        chk_all(16'h0000, 1'b1);
        mv(1'b0, 4);
        chk_all(16'h0002, 1'b0);
    endtask

    // x4 max wrap, then counting off with direction still tracked
    task automatic s_x4_max_off();
        set_mode(MODE_X4_MAX, 16'h0003);
        mv(1'b1, 4);
        chk_all(16'h0002, 1'b1);
        set_mode(3'h3, 16'h0003);
        mv(1'b0, 1);
        chk_all(16'h0002, 1'b0);
        mv(1'b1, 1);
        chk_all(16'h0002, 1'b1);
    endtask

    // x2 with index reset
    task automatic s_x2_index();
        set_mode(MODE_X2_INDEX, 16'h0003);
        mv(1'b1, 4);
        chk_all(16'h0004, 1'b1);
        enc_inst.pulse_index();
        chk_all(16'h0000, 1'b1);
    endtask

    // Enable low freezes everything; the held A edge is counted once it returns
    task automatic s_freeze();
        @(posedge clk);
        clk_en <= 1'b0;
        mv(1'b1, 1);
        chk_all(16'h0000, 1'b1);
        clk_en <= 1'b1;
        repeat (6) @(posedge clk);
        chk_all(16'h0001, 1'b1);
    endtask

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial
    begin
        clk         = 1'b0;
        sys_rst     = 1'b1;
        clk_en      = 1'b1;
        mode        = 3'h0;
        limit       = 16'h0000;
        bad_count   = 0;
        comparisons = 0;
        pulses      = 0;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk_all(16'h0000, 1'b0);
        s_x4_index();
        s_x2_max();
        s_x4_max_off();
        s_x2_index();
        s_freeze();
        chk("pulses", pulses[15:0], 16'h001b);
        results();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        results();
    end
endmodule
`default_nettype wire
